// ===== hdl/antistall_config_fault_flags.sv
// Anti-stall configuration, current floor control, fault flags and standby
`timescale 1ns/1ps
module antistall_config_fault_flags
	import stall_cfg_pkg::*;
#(
	parameter int LOW_CYCLES = PERIOD_LOW_CYCLES,
	parameter int MID_CYCLES = PERIOD_MID_CYCLES,
	parameter int HIGH_CYCLES = PERIOD_HIGH_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input stall_cfg_pkg::reg_req_type reg_req_i,
	output logic [31:0] read_data_o,
	input wire logic serial_mode_i,
	input wire logic anti_stall_gain_i,
	input wire logic floor_select_low_i,
	input stall_cfg_pkg::level4_type floor_select_mid_i,
	input stall_cfg_pkg::level4_type boost_level_pin_i,
	input stall_cfg_pkg::level4_type rate_limit_pin_i,
	input wire logic step_clock_i,
	input wire logic [2:0] step_div_i,
	input wire logic load_light_i,
	input wire logic load_heavy_i,
	input wire logic thermal_shutdown_i,
	input wire logic overcurrent_detect_i,
	input wire logic open_load_detect_i,
	input wire logic motor_supply_ok_i,
	input wire logic standby_n_i,
	output stall_cfg_pkg::fault_flags_type fault_flags_o,
	output logic osc_enable_o,
	output logic outputs_enable_o,
	output logic anti_stall_active_o,
	output logic [6:0] current_pct_o,
	output logic [6:0] floor_pct_o,
	output logic [3:0] boost_steps_o,
	output logic [COMMAND_WIDTH-1:0] command_o
);
	localparam int CFG_PINS = 8;
	localparam int ASYNC_PINS = CFG_PINS + 9;

	typedef struct packed {
		logic [ASYNC_PINS-1:0] sync1;
		logic [ASYNC_PINS-1:0] sync2;
		logic step_prev;
		logic light_prev;
		logic heavy_prev;
		logic supply_prev;
		logic [7:0] config_bits;
		logic [COMMAND_WIDTH-1:0] command;
		logic serial_step;
		fault_code_type fault_code;
		fault_flags_type flags;
		logic osc_enable;
		logic outputs_enable;
		logic active;
		logic [6:0] current_pct;
		logic [6:0] floor_pct;
		logic [3:0] boost_steps;
		logic [31:0] read_data;
	} top_state_type;

	top_state_type state_reg;
	top_state_type state_next;
	logic [CFG_PINS-1:0] pins_clean;
	logic rate_ok;
	logic step_event;

	// Synchronised pin fields
	logic serial_mode;
	logic step_level;
	logic light_level;
	logic heavy_level;
	logic tsd_level;
	logic isd_level;
	logic opd_level;
	logic supply_level;
	logic standby_n;

	// Selected configuration
	logic gain_enable;
	logic [2:0] floor_code;
	logic [1:0] boost_code;
	rate_code_type rate_code;
	logic [6:0] floor_value;
	logic [3:0] step_count;
	logic [6:0] boost_delta;
	logic [6:0] raised;
	fault_code_type fault_seen;
	logic fault_clear;

	assign {serial_mode, step_level, light_level, heavy_level, tsd_level, isd_level,
		opd_level, supply_level, standby_n} = state_reg.sync2[ASYNC_PINS-1:CFG_PINS];

	glitch_filter #(
		.WIDTH(CFG_PINS),
		.CYCLES(FILTER_CYCLES)
	) pin_filter (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.raw_i(state_reg.sync2[CFG_PINS-1:0]),
		.clean_o(pins_clean)
	);

	// Clock mode steps on the pin edge; serial mode steps on each changed command
	assign step_event = serial_mode ? state_reg.serial_step :
		(step_level && !state_reg.step_prev);

	step_rate_meter #(
		.LOW_CYCLES(LOW_CYCLES),
		.MID_CYCLES(MID_CYCLES),
		.HIGH_CYCLES(HIGH_CYCLES)
	) rate_meter (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.step_i(step_event),
		.rate_code_i(rate_code),
		.step_div_i(step_div_i),
		.rate_ok_o(rate_ok)
	);

	always_comb begin
		// Pins and register bits share one encoding, so one decoder serves both
		if (serial_mode) begin
			gain_enable = state_reg.config_bits[CFG_GAIN_BIT];
			floor_code = state_reg.config_bits[CFG_FLOOR_LSB +: 3];
			boost_code = state_reg.config_bits[CFG_BOOST_LSB +: 2];
			rate_code = rate_code_type'(state_reg.config_bits[CFG_RATE_LSB +: 2]);
		end else begin
			// The enable pin is taken as steady once filtered
			gain_enable = pins_clean[7];
			floor_code = pins_clean[6:4];
			boost_code = pins_clean[3:2];
			rate_code = rate_code_type'(pins_clean[1:0]);
		end
		floor_value = floor_pct(floor_code);
		step_count = boost_steps(boost_code);
		// Recovery step size so full current returns within the chosen step count
		boost_delta = 7'((FULL_PCT - floor_value + 7'(step_count) - 7'h01) / 7'(step_count));
		raised = 7'(state_reg.current_pct + boost_delta);
		if (raised > FULL_PCT) begin
			raised = FULL_PCT;
		end
		fault_seen = FAULT_NONE;
		if (tsd_level) begin
			fault_seen = FAULT_THERMAL;
		end else if (isd_level) begin
			fault_seen = FAULT_OVERCURRENT;
		end else if (opd_level) begin
			fault_seen = FAULT_OPEN_LOAD;
		end
		fault_clear = !standby_n || (supply_level && !state_reg.supply_prev);
	end

	always_comb begin
		state_next = state_reg;
		state_next.sync1 = {serial_mode_i, step_clock_i, load_light_i, load_heavy_i,
			thermal_shutdown_i, overcurrent_detect_i, open_load_detect_i, motor_supply_ok_i,
			standby_n_i, anti_stall_gain_i, floor_select_low_i, floor_select_mid_i,
			boost_level_pin_i, rate_limit_pin_i};
		state_next.sync2 = state_reg.sync1;
		state_next.step_prev = step_level;
		state_next.light_prev = light_level;
		state_next.heavy_prev = heavy_level;
		state_next.supply_prev = supply_level;

		// Register port
		state_next.serial_step = 1'b0;
		if (reg_req_i.write) begin
			if (reg_req_i.addr == CONFIG_OFFSET) begin
				state_next.config_bits = reg_req_i.write_data[7:0];
			end else if (reg_req_i.addr == COMMAND_OFFSET) begin
				state_next.command = reg_req_i.write_data[COMMAND_WIDTH-1:0];
				state_next.serial_step =
					reg_req_i.write_data[COMMAND_WIDTH-1:0] != state_reg.command;
			end
		end
		state_next.read_data = 32'h00000000;
		if (reg_req_i.read) begin
			unique case (reg_req_i.addr)
				CONFIG_OFFSET: state_next.read_data[7:0] = state_reg.config_bits;
				COMMAND_OFFSET: state_next.read_data[COMMAND_WIDTH-1:0] = state_reg.command;
				STATUS_OFFSET: begin
					state_next.read_data[ST_FAULT_LSB +: 2] = state_reg.fault_code;
					state_next.read_data[ST_ACTIVE_BIT] = state_reg.active;
					state_next.read_data[ST_RATE_OK_BIT] = rate_ok;
					state_next.read_data[ST_SERIAL_BIT] = serial_mode;
					state_next.read_data[ST_CURRENT_LSB +: 7] = state_reg.current_pct;
					state_next.read_data[ST_FLOOR_LSB +: 7] = state_reg.floor_pct;
					state_next.read_data[ST_BOOST_LSB +: 4] = state_reg.boost_steps;
				end
				default: state_next.read_data = 32'h00000000;
			endcase
		end

		// Fault latch: a new fault in the clearing cycle still wins
		if (fault_clear) begin
			state_next.fault_code = fault_seen;
		end else if (fault_seen > state_reg.fault_code) begin
			state_next.fault_code = fault_seen;
		end
		// Open drain: data stays low, enable pulls the pin down
		state_next.flags.a_out = 1'b0;
		state_next.flags.b_out = 1'b0;
		state_next.flags.a_oe = state_next.fault_code[1];
		state_next.flags.b_oe = state_next.fault_code[0];

		state_next.osc_enable = standby_n;
		state_next.outputs_enable = standby_n;

		// Current control
		state_next.active = standby_n && gain_enable && rate_ok;
		state_next.floor_pct = floor_value;
		state_next.boost_steps = step_count;
		if (!state_reg.active) begin
			state_next.current_pct = FULL_PCT;
		end else if (heavy_level && !state_reg.heavy_prev) begin
			state_next.current_pct = raised;
		end else if (state_reg.current_pct < floor_value) begin
			state_next.current_pct = floor_value;
		end else if (light_level && !state_reg.light_prev &&
			state_reg.current_pct > floor_value) begin
			state_next.current_pct = 7'(state_reg.current_pct - 7'h01);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.config_bits <= CONFIG_RESET;
			state_reg.command <= COMMAND_RESET;
			state_reg.current_pct <= FULL_PCT;
			state_reg.floor_pct <= FLOOR_BASE_PCT;
			state_reg.boost_steps <= BOOST_MAX_STEPS;
		end else begin
			state_reg <= state_next;
		end
	end

	assign read_data_o = state_reg.read_data;
	assign fault_flags_o = state_reg.flags;
	assign osc_enable_o = state_reg.osc_enable;
	assign outputs_enable_o = state_reg.outputs_enable;
	assign anti_stall_active_o = state_reg.active;
	assign current_pct_o = state_reg.current_pct;
	assign floor_pct_o = state_reg.floor_pct;
	assign boost_steps_o = state_reg.boost_steps;
	assign command_o = state_reg.command;
endmodule

// ===== include/stall_cfg_pkg.sv
// Shared constants, types and helpers for the anti-stall configuration block
package stall_cfg_pkg;
	localparam int CLOCK_HZ = 40_000_000;
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int FILTER_NS = 625;
	localparam int FILTER_CYCLES = (FILTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int RATE_LOW_HZ = 225;
	localparam int RATE_MID_HZ = 450;
	localparam int RATE_HIGH_HZ = 675;
	localparam int PERIOD_LOW_CYCLES = CLOCK_HZ / RATE_LOW_HZ;
	localparam int PERIOD_MID_CYCLES = CLOCK_HZ / RATE_MID_HZ;
	localparam int PERIOD_HIGH_CYCLES = CLOCK_HZ / RATE_HIGH_HZ;
	localparam int PERIOD_WIDTH = 20;
	localparam logic [6:0] FULL_PCT = 7'h64;
	localparam logic [6:0] FLOOR_BASE_PCT = 7'h2d;
	localparam logic [6:0] FLOOR_STEP_PCT = 7'h05;
	localparam logic [3:0] BOOST_MAX_STEPS = 4'hb;
	localparam logic [3:0] BOOST_STEP_DELTA = 4'h2;
	localparam int ADDR_WIDTH = 4;
	localparam logic [ADDR_WIDTH-1:0] CONFIG_OFFSET = 4'h0;
	localparam logic [ADDR_WIDTH-1:0] COMMAND_OFFSET = 4'h4;
	localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 4'h8;
	localparam int CFG_GAIN_BIT = 0;
	localparam int CFG_FLOOR_LSB = 1;
	localparam int CFG_BOOST_LSB = 4;
	localparam int CFG_RATE_LSB = 6;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam int COMMAND_WIDTH = 22;
	localparam logic [COMMAND_WIDTH-1:0] COMMAND_RESET = 22'h000000;
	localparam int ST_FAULT_LSB = 0;
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_RATE_OK_BIT = 3;
	localparam int ST_SERIAL_BIT = 4;
	localparam int ST_CURRENT_LSB = 8;
	localparam int ST_FLOOR_LSB = 16;
	localparam int ST_BOOST_LSB = 24;

	typedef enum logic [1:0] {
		FAULT_NONE = 2'b00,
		FAULT_OPEN_LOAD = 2'b01,
		FAULT_OVERCURRENT = 2'b10,
		FAULT_THERMAL = 2'b11
	} fault_code_type;

	// Four-level pin as reported by the level detector
	typedef enum logic [1:0] {
		LEVEL_GND_SHORT = 2'b00,
		LEVEL_PULL_DOWN = 2'b01,
		LEVEL_PULL_UP = 2'b10,
		LEVEL_SUPPLY_SHORT = 2'b11
	} level4_type;

	typedef enum logic [1:0] {
		RATE_OFF = 2'b00,
		RATE_LOW = 2'b01,
		RATE_MID = 2'b10,
		RATE_HIGH = 2'b11
	} rate_code_type;

	typedef struct packed {
		logic [ADDR_WIDTH-1:0] addr;
		logic [31:0] write_data;
		logic write;
		logic read;
	} reg_req_type;

	typedef struct packed {
		logic a_out;
		logic a_oe;
		logic b_out;
		logic b_oe;
	} fault_flags_type;

	function automatic logic [6:0] floor_pct(input logic [2:0] code);
		floor_pct = 7'(FLOOR_BASE_PCT + FLOOR_STEP_PCT * code);
	endfunction

	function automatic logic [3:0] boost_steps(input logic [1:0] code);
		boost_steps = 4'(BOOST_MAX_STEPS - BOOST_STEP_DELTA * code);
	endfunction
endpackage

// ===== hdl/glitch_filter.sv
// Accepts a level only after it has stood unchanged for a set number of cycles
`timescale 1ns/1ps
module glitch_filter #(
	parameter int WIDTH = 8,
	parameter int CYCLES = 25
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] raw_i,
	output logic [WIDTH-1:0] clean_o
);
	typedef struct packed {
		logic [WIDTH-1:0] candidate;
		logic [7:0] count;
		logic [WIDTH-1:0] clean;
	} filter_state_type;

	filter_state_type state_reg;
	filter_state_type state_next;

	always_comb begin
		state_next = state_reg;
		if (raw_i != state_reg.candidate) begin
			state_next.candidate = raw_i;
			state_next.count = 8'h00;
		end else if (state_reg.count == 8'(CYCLES - 1)) begin
			state_next.clean = state_reg.candidate;
		end else begin
			state_next.count = 8'(state_reg.count + 8'h01);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign clean_o = state_reg.clean;
endmodule

// ===== hdl/step_rate_meter.sv
// Measures the step period and flags when the step rate is at or above the limit
`timescale 1ns/1ps
module step_rate_meter
	import stall_cfg_pkg::*;
#(
	parameter int LOW_CYCLES = PERIOD_LOW_CYCLES,
	parameter int MID_CYCLES = PERIOD_MID_CYCLES,
	parameter int HIGH_CYCLES = PERIOD_HIGH_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic step_i,
	input stall_cfg_pkg::rate_code_type rate_code_i,
	input wire logic [2:0] step_div_i,
	output logic rate_ok_o
);
	typedef struct packed {
		logic [PERIOD_WIDTH-1:0] count;
		logic [PERIOD_WIDTH-1:0] last_period;
		logic rate_ok;
	} meter_state_type;

	meter_state_type state_reg;
	meter_state_type state_next;
	logic [PERIOD_WIDTH-1:0] threshold;

	always_comb begin
		unique case (rate_code_i)
			RATE_OFF: threshold = '1;
			RATE_LOW: threshold = PERIOD_WIDTH'(LOW_CYCLES);
			RATE_MID: threshold = PERIOD_WIDTH'(MID_CYCLES);
			RATE_HIGH: threshold = PERIOD_WIDTH'(HIGH_CYCLES);
		endcase
		// Threshold rate doubles with each halving of the step size
		threshold = threshold >> step_div_i;
		state_next = state_reg;
		if (step_i) begin
			state_next.count = '0;
			state_next.last_period = state_reg.count;
		end else if (state_reg.count != '1) begin
			state_next.count = PERIOD_WIDTH'(state_reg.count + 1'b1);
		end
		// A stalled or slow step train counts as below the limit
		state_next.rate_ok = (rate_code_i == RATE_OFF) ||
			((state_reg.last_period <= threshold) && (state_reg.count <= threshold));
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= {{PERIOD_WIDTH{1'b1}}, {PERIOD_WIDTH{1'b1}}, 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rate_ok_o = state_reg.rate_ok;
endmodule

// ===== sim/antistall_config_fault_flags_sva.sv
// Port-level checker for the anti-stall configuration block
`timescale 1ns/1ps
module antistall_checker (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic thermal_shutdown_i,
	input wire logic overcurrent_detect_i,
	input wire logic open_load_detect_i,
	input wire logic motor_supply_ok_i,
	input wire logic standby_n_i,
	input stall_cfg_pkg::fault_flags_type fault_flags_o,
	input wire logic osc_enable_o,
	input wire logic outputs_enable_o,
	input wire logic anti_stall_active_o,
	input wire logic [6:0] current_pct_o,
	input wire logic [6:0] floor_pct_o,
	input wire logic [3:0] boost_steps_o
);
	import stall_cfg_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_flag_never_high: assert property (!fault_flags_o.a_out && !fault_flags_o.b_out)
		else $error("fault flag driven high");
	chk_thermal_both_low: assert property (thermal_shutdown_i[*4] |=>
		fault_flags_o.a_oe && fault_flags_o.b_oe) else $error("thermal not on both flags");
	chk_overcurrent_flag: assert property (overcurrent_detect_i[*4] |=> fault_flags_o.a_oe)
		else $error("overcurrent flag missing");
	// A held overcurrent or thermal code outranks a later open load
	chk_open_load_flag: assert property (open_load_detect_i[*4] |=>
		fault_flags_o.b_oe || fault_flags_o.a_oe) else $error("open load flag missing");
	chk_fault_held: assert property ((standby_n_i && motor_supply_ok_i)[*6] |->
		!$fell(fault_flags_o.a_oe) && (!$fell(fault_flags_o.b_oe) || fault_flags_o.a_oe))
		else $error("fault flag released without clear");
	chk_standby_stops: assert property (!standby_n_i[*4] |=>
		!osc_enable_o && !outputs_enable_o && !anti_stall_active_o) else $error("standby ignored");
	chk_standby_resume: assert property (standby_n_i[*4] |=> osc_enable_o && outputs_enable_o)
		else $error("outputs not restored");
	chk_inactive_full: assert property (!anti_stall_active_o[*2] |-> current_pct_o == FULL_PCT)
		else $error("current reduced while inactive");
	chk_active_range: assert property (anti_stall_active_o |->
		current_pct_o >= floor_pct_o && current_pct_o <= FULL_PCT) else $error("current out of range");
	chk_floor_legal: assert property (floor_pct_o inside {[7'h2d:7'h50]} && floor_pct_o % 5 == 0)
		else $error("illegal floor");
	chk_boost_legal: assert property (boost_steps_o inside {4'h5, 4'h7, 4'h9, 4'hb})
		else $error("illegal boost count");
endmodule

// ===== sim/host_step_source.sv
// Host model: step clock generator and the fixed anti-stall enable level
`timescale 1ns/1ps
module host_step_source #(
	parameter logic GAIN_LEVEL = 1'b1
) (
	input wire logic clock_i,
	input wire logic run_i,
	input wire logic [15:0] period_i,
	output logic step_clock_o,
	output logic gain_pin_o
);
	logic [15:0] count_reg = 16'h0;
	initial step_clock_o = 1'b0;
	// Enable level never changes while powered
	assign gain_pin_o = GAIN_LEVEL;
	// Step line stands low while not running
	always @(posedge clock_i) begin
		if (!run_i || count_reg >= period_i - 16'h1) begin
			count_reg <= 16'h0;
		end else begin
			count_reg <= count_reg + 16'h1;
		end
		step_clock_o <= run_i && (count_reg < (period_i >> 1));
	end
endmodule

// ===== sim/antistall_config_fault_flags_bench.sv
// Self-checking bench for the anti-stall configuration and fault flag block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	#1; \
	check_count++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module antistall_config_fault_flags_bench;
	import stall_cfg_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	reg_req_type req = '0;
	logic serial = 1'b0, floor_low = 1'b0, run = 1'b0, stby_n = 1'b1, supply = 1'b1;
	level4_type floor_mid = LEVEL_GND_SHORT, boost_pin = LEVEL_GND_SHORT, rate_pin = LEVEL_GND_SHORT;
	logic [2:0] div = 3'h0, flt = 3'h0;
	logic [1:0] ld = 2'h0;
	logic gain_pin, step_clock, osc_en, out_en, active;
	logic [31:0] rdata, d;
	fault_flags_type flags;
	logic [6:0] cur, floor_pct;
	logic [3:0] boost;
	logic [COMMAND_WIDTH-1:0] cmd;
	int mismatches = 0;
	int check_count = 0;
	int ncmd = 0;
	always #12.5 clock_i = ~clock_i;
	host_step_source host (.clock_i(clock_i), .run_i(run), .period_i(16'h30),
		.step_clock_o(step_clock), .gain_pin_o(gain_pin));
	antistall_config_fault_flags #(.LOW_CYCLES(400), .MID_CYCLES(200), .HIGH_CYCLES(100)) uut (
		.clock_i(clock_i), .rst_i(rst_i), .reg_req_i(req), .read_data_o(rdata),
		.serial_mode_i(serial), .anti_stall_gain_i(gain_pin), .floor_select_low_i(floor_low),
		.floor_select_mid_i(floor_mid), .boost_level_pin_i(boost_pin), .rate_limit_pin_i(rate_pin),
		.step_clock_i(step_clock), .step_div_i(div), .load_light_i(ld[0]), .load_heavy_i(ld[1]),
		.thermal_shutdown_i(flt[2]), .overcurrent_detect_i(flt[1]), .open_load_detect_i(flt[0]),
		.motor_supply_ok_i(supply), .standby_n_i(stby_n), .fault_flags_o(flags),
		.osc_enable_o(osc_en), .outputs_enable_o(out_en), .anti_stall_active_o(active),
		.current_pct_o(cur), .floor_pct_o(floor_pct), .boost_steps_o(boost), .command_o(cmd));
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock_i);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clock_i);
		req.write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock_i);
		req.read <= 1'b0;
		#1 d = rdata;
	endtask
	// Bits 4..3 load heavy/light, 2..0 thermal, overcurrent, open load
	task automatic pulse(input logic [4:0] m);
		@(posedge clock_i);
		{ld, flt} <= m;
		tick(6);
		{ld, flt} <= 5'h0;
		tick(6);
	endtask
	task automatic steps(input int n);
		for (int i = 0; i < n; i++) begin
			ncmd++;
			wr(COMMAND_OFFSET, 32'(ncmd));
			tick(48);
		end
	endtask
	task automatic t_reset;
		`CHK(cur, 7'h64)
		`CHK(flags, 4'h0)
		`CHK(boost, 4'hb)
	endtask
	task automatic t_pins;
		for (int lo = 0; lo < 2; lo++) begin
			for (int lv = 0; lv < 4; lv++) begin
				floor_low <= lo[0];
				floor_mid <= level4_type'(lv);
				boost_pin <= level4_type'(lv);
				tick(40);
				`CHK(floor_pct, 7'(45 + 20 * lo + 5 * lv))
				`CHK(boost, 4'(11 - 2 * lv))
			end
		end
		floor_low <= 1'b0;
		floor_mid <= LEVEL_GND_SHORT;
		boost_pin <= LEVEL_GND_SHORT;
		tick(40);
		floor_low <= 1'b1;
		tick(18);
		`CHK(floor_pct, 7'h2d)
		floor_low <= 1'b0;
		tick(40);
		`CHK(floor_pct, 7'h2d)
	endtask
	task automatic t_serial;
		serial <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(CONFIG_OFFSET, 32'((c << 1) | ((c & 3) << 4)));
			tick(3);
			`CHK(floor_pct, 7'(45 + 5 * c))
			`CHK(boost, 4'(11 - 2 * (c & 3)))
		end
		rd(STATUS_OFFSET);
		`CHK(d[22:16], 7'h50)
		`CHK(d[4], 1'b1)
		rd(4'hc);
		`CHK(d, 32'h0)
		wr(CONFIG_OFFSET, 32'hc1);
		steps(6);
		`CHK(active, 1'b1)
		wr(CONFIG_OFFSET, 32'hc0);
		steps(2);
		`CHK(active, 1'b0)
		`CHK(cmd, 22'h8)
		wr(CONFIG_OFFSET, 32'hc1);
		tick(300);
		`CHK(active, 1'b0)
		serial <= 1'b0;
	endtask
	task automatic t_rate;
		rate_pin <= LEVEL_SUPPLY_SHORT;
		tick(40);
		`CHK(active, 1'b0)
		run <= 1'b1;
		tick(300);
		`CHK(active, 1'b1)
		`CHK(cur, 7'h64)
		repeat (8) pulse(5'b01000);
		`CHK(cur, 7'h5c)
		pulse(5'b10000);
		`CHK(cur, 7'h61)
		div <= 3'h1;
		tick(200);
		`CHK(active, 1'b1)
		div <= 3'h2;
		tick(200);
		`CHK(active, 1'b0)
		`CHK(cur, 7'h64)
		// Pull-up level: 200 cycle limit, step period 48
		rate_pin <= LEVEL_PULL_UP;
		tick(60);
		`CHK(active, 1'b1)
		div <= 3'h3;
		tick(10);
		`CHK(active, 1'b0)
		// Pull-down level: 400 cycle limit
		rate_pin <= LEVEL_PULL_DOWN;
		tick(60);
		`CHK(active, 1'b1)
		div <= 3'h4;
		tick(10);
		`CHK(active, 1'b0)
		div <= 3'h0;
		run <= 1'b0;
		rate_pin <= LEVEL_GND_SHORT;
		tick(60);
		`CHK(active, 1'b1)
	endtask
	task automatic t_faults;
		pulse(5'b00001);
		`CHK(flags, 4'h1)
		pulse(5'b00100);
		`CHK(flags, 4'h5)
		stby_n <= 1'b0;
		tick(8);
		`CHK({osc_en, out_en, active}, 3'h0)
		stby_n <= 1'b1;
		tick(8);
		`CHK(flags, 4'h0)
		`CHK({osc_en, out_en}, 2'h3)
		pulse(5'b00010);
		pulse(5'b00001);
		`CHK(flags, 4'h4)
		supply <= 1'b0;
		tick(8);
		supply <= 1'b1;
		tick(8);
		`CHK(flags, 4'h0)
	endtask
	task automatic test_done;
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		tick(10);
		rst_i <= 1'b0;
		tick(2);
		t_reset;
		t_pins;
		t_serial;
		t_rate;
		t_faults;
		test_done;
	end
	initial begin
		tick(20000);
		mismatches++;
		test_done;
	end
endmodule
bind antistall_config_fault_flags antistall_checker chk (.clock_i, .rst_i, .thermal_shutdown_i,
	.overcurrent_detect_i, .open_load_detect_i, .motor_supply_ok_i, .standby_n_i, .fault_flags_o,
	.osc_enable_o, .outputs_enable_o, .anti_stall_active_o, .current_pct_o, .floor_pct_o,
	.boost_steps_o);
